// ### test/sarh_monitor.sv
// concurrent checks on the link between host port and converters
`timescale 1ns/1ns
module sarh_monitor (
  // clock and reset
  input wire logic                             core_clk_in,
  input wire logic                             rst_in,
  // link signals
  input wire logic                             conv_clk,
  input wire logic [2*sarh_pkg::SARH_CONV-1:0] ctrl_port,
  input wire logic [sarh_pkg::SARH_FLAG_W-1:0] flag_port,
  input wire logic [sarh_pkg::SARH_CONV-1:0]
                   [sarh_pkg::SARH_BITS-1:0]   res_data,
  input wire logic [sarh_pkg::SARH_CONV-1:0]   res_oe,
  input wire logic [sarh_pkg::SARH_BITS-1:0]   result_bus
);
  import sarh_pkg::*;
  default clocking @(posedge core_clk_in); endclocking
  default disable iff (rst_in);

  logic       conv_q;
  logic [3:0] n_fall;

  // falls of the converter clock since channel 0 trigger went high
  always_ff @(posedge core_clk_in) begin
    conv_q <= conv_clk;
    if (rst_in || !ctrl_port[0])
      n_fall <= 4'h0;
    else if (conv_q && !conv_clk)
      n_fall <= n_fall + 4'h1;
  end

  chk_trig_preset: assert property (!ctrl_port[0] |=>
    res_data[0] == SARH_PRESET && !flag_port[0])
    else $error("trigger did not preset result and clear done");
  chk_trig_width: assert property ($fell(ctrl_port[0]) |->
    !ctrl_port[0] [*8] ##1 !ctrl_port[0] [*7])
    else $error("trigger low too short");
  chk_trig_on_rise: assert property ($rose(ctrl_port[0]) |->
    $rose(conv_clk))
    else $error("trigger released off a clock rise");
  chk_clock_div: assert property ($rose(conv_clk) |=>
    conv_clk ##1 !conv_clk [*2] ##1 conv_clk)
    else $error("converter clock not core clock over four");
  chk_done_ninth: assert property ($rose(flag_port[0]) |->
    n_fall == 4'h9)
    else $error("done not on ninth fall");
  chk_result_hold: assert property (flag_port[0] && ctrl_port[0]
    |=> $stable(res_data[0]))
    else $error("result changed without trigger");
  chk_bus_drive: assert property (res_oe[0] |->
    result_bus == res_data[0])
    else $error("bus does not show enabled result");
  chk_oe_single: assert property ($onehot0(ctrl_port[7:4]) &&
    $onehot0(res_oe))
    else $error("more than one result enable");
  chk_oe_follow: assert property ($rose(ctrl_port[4]) |->
    ##[1:2] res_oe[0])
    else $error("result enable did not follow control port");
  chk_flag_spare: assert property (flag_port[5:4] == 2'h0)
    else $error("spare flag pins not low");
endmodule : sarh_monitor

// ### test/test_sar_adc_sequencer_host_port.sv
// self-checking bench: host port and converters joined by the link
`timescale 1ns/1ns
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_fail++; \
  $display("wrong value at %0t: got %h want %h", $time, (a), (b)); end end
module test_sar_adc_sequencer_host_port;
  import sarh_pkg::*;
  logic                 clk = 1'b0;
  logic                 rst;
  logic                 hsel, hwrite, hready, hresp;
  logic [31:0]          haddr, hwdata, hrdata, rd;
  logic [1:0]           htrans;
  logic [2:0]           hsize;
  logic [SARH_CONV-1:0] comp;
  logic [7:0]           lvl [SARH_CONV];
  logic [7:0]           codes [3] = '{8'h7F, 8'h01, 8'hFE};
  int                   n_fail = 0;
  int                   n_tests = 0;

  // 10 MHz core clock
  always #50 clk = ~clk;

  sarh_if link ();
  sarh_host i_sarh_host (.core_clk_in(clk), .rst_in(rst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite),
    .hsize_in(hsize), .hwdata_in(hwdata), .hready_in(hready),
    .hreadyout_out(hready), .hrdata_out(hrdata), .hresp_out(hresp),
    .link(link));
  sarh_device i_sarh_device (.core_clk_in(clk), .rst_in(rst),
    .comp_in(comp), .link(link));
  sarh_monitor i_sarh_monitor (.core_clk_in(clk), .rst_in(rst),
    .conv_clk(link.conv_clk), .ctrl_port(link.ctrl_port),
    .flag_port(link.flag_port), .res_data(link.res_data),
    .res_oe(link.res_oe), .result_bus(link.result_bus));

  // comparator: high while trial code is not above the level
  always @(posedge clk) begin
    for (int i = 0; i < SARH_CONV; i++) begin
      comp[i] <= (link.res_data[i] <= lvl[i]);
    end
  end

  // one single ahb-lite transfer, address phase then data phase
  task automatic ahb(input logic wr, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] d);
    hsel   <= 1'b1;
    haddr  <= {24'h000000, a};
    htrans <= SARH_HTRANS_NONSEQ;
    hwrite <= wr;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    d = hrdata;
    `CHK(hresp, SARH_HRESP_OKAY)
  endtask : ahb

  // read and compare
  task automatic rdc(input logic [7:0] a, input logic [31:0] e);
    logic [31:0] d;
    ahb(1'b0, a, 32'h0, d);
    `CHK(d, e)
  endtask : rdc

  // poll status until every converter reports done
  task automatic wait_done();
    logic [31:0] d;
    int          n;
    n = 0;
    do begin
      ahb(1'b0, SARH_REG_STATUS, 32'h0, d);
      n++;
    end while (d[3:0] !== 4'hF && n < 100);
    `CHK(d, 32'h0F)
  endtask : wait_done

  // verdict and end of run
  task automatic results();
    $display("comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask : results

  // watchdog against a hang
  initial begin
    #(6000 * 100);
    n_fail++;
    results();
  end

  // main sequence
  initial begin
    rst = 1'b1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'h2;
    lvl = '{8'h00, 8'hFF, 8'h80, 8'h5A};
    repeat (16) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    // idle values and an unmapped place
    rdc(SARH_REG_STATUS, 32'h0F);
    ahb(1'b1, 8'h10, 32'hF, rd);
    rdc(8'h10, 32'h0);
    rdc(SARH_REG_OESEL, 32'h0);
    // all four at once, busy while converting
    ahb(1'b1, SARH_REG_START, 32'hF, rd);
    rdc(SARH_REG_START, 32'hF);
    rdc(SARH_REG_STATUS, 32'h0);
    wait_done();
    for (int i = 0; i < SARH_CONV; i++) begin
      ahb(1'b1, SARH_REG_OESEL, 32'h1 << i, rd);
      rdc(SARH_REG_OESEL, 32'h1 << i);
      rdc(SARH_REG_DATA, {24'h0, lvl[i]});
    end
    // two bits asked, lowest kept; level moves, result holds
    ahb(1'b1, SARH_REG_OESEL, 32'h6, rd);
    rdc(SARH_REG_OESEL, 32'h2);
    lvl[1] <= 8'h3C;
    rdc(SARH_REG_DATA, 32'hFF);
    // channel 1 alone; status lags the start, so read busy first
    ahb(1'b1, SARH_REG_START, 32'h2, rd);
    rdc(SARH_REG_START, 32'h2);
    wait_done();
    rdc(SARH_REG_DATA, 32'h3C);
    // bus sample needs two cycles after the enable moves
    ahb(1'b1, SARH_REG_OESEL, 32'h1, rd);
    rdc(SARH_REG_OESEL, 32'h1);
    rdc(SARH_REG_DATA, 32'h00);
    // codes around the msb boundary and the ends
    for (int k = 0; k < 3; k++) begin
      lvl[0] <= codes[k];
      ahb(1'b1, SARH_REG_START, 32'h1, rd);
      rdc(SARH_REG_START, 32'h1);
      wait_done();
      rdc(SARH_REG_DATA, {24'h0, codes[k]});
    end
    ahb(1'b1, SARH_REG_OESEL, 32'h0, rd);
    results();
  end
endmodule : test_sar_adc_sequencer_host_port

// ### verilog/sarh_device.sv
// converter end: four channels on the shared result bus
`timescale 1ns/1ns
module sarh_device (
  // clock and reset
  input  wire logic                        core_clk_in,
  input  wire logic                        rst_in,
  // comparator decisions, one per channel
  input  wire logic [sarh_pkg::SARH_CONV-1:0] comp_in,
  // link to the host
  sarh_if.device                           link
);
  import sarh_pkg::*;

  logic                 conv_clk_q;
  logic                 next_conv_clk_q;
  logic                 conv_fall;
  logic [SARH_CONV-1:0] done;

  // converter clock history for edge detect
  always_comb begin
    next_conv_clk_q = link.conv_clk;
  end

  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      conv_clk_q <= 1'b0;
    end else begin
      conv_clk_q <= next_conv_clk_q;
    end
  end

  assign conv_fall = conv_clk_q & ~link.conv_clk;

  // channels: lower control bits trigger, upper bits enable
  for (genvar g = 0; g < SARH_CONV; g++) begin : g_chan
    sarh_sar_chan u_chan (
      .core_clk_in   (core_clk_in),
      .rst_in        (rst_in),
      .conv_fall_in  (conv_fall),
      .trigger_n_in  (link.ctrl_port[g]),
      .comp_in       (comp_in[g]),
      .oe_in         (link.ctrl_port[SARH_CONV+g]),
      .result_out    (link.res_data[g]),
      .result_oe_out (link.res_oe[g]),
      .done_out      (done[g])
    );
  end

  // done flags on the low flag pins, spare pins low
  assign link.flag_port = {2'b00, done};
endmodule : sarh_device

// ### verilog/sarh_host.sv
// host end: ahb-lite register port, converter clock and triggers
// How it works
// - converter resolves 8 bits, one per step
// - trigger low at least 1.5 us before fall
// - trigger release kept 200 ns off falls
// - clock-aligned trigger pulse also acceptable
// - trigger presets result to msb only
// - first fall decides msb from comparator
// - each decision sets next lower trial bit
// - done high only when all bits decided; reset also sets done high
// - result held until next trigger
// - outputs driven only while enable high
// - host reads shared 8-bit result bus
// - control port: low triggers, high enables
// - done flags read on flag port pins
// - converter clock is core clock over 4
// - at most one converter enabled at once
// - each converter has its own trigger flop
// - trigger flop cleared, released on rise
// - done rises on ninth falling edge
`timescale 1ns/1ns
module sarh_host (
  // clock and reset
  input  wire logic         core_clk_in,
  input  wire logic         rst_in,
  // ahb-lite slave port
  input  wire logic         hsel_in,
  input  wire logic [31:0]  haddr_in,
  input  wire logic [1:0]   htrans_in,
  input  wire logic         hwrite_in,
  input  wire logic [2:0]   hsize_in,
  input  wire logic [31:0]  hwdata_in,
  input  wire logic         hready_in,
  output logic              hreadyout_out,
  output logic [31:0]       hrdata_out,
  output logic              hresp_out,
  // link to the converters
  sarh_if.host              link
);
  import sarh_pkg::*;

  // keeps only the lowest requested enable
  function automatic logic [SARH_CONV-1:0] lowest_one(
    input logic [SARH_CONV-1:0] req
  );
    logic [SARH_CONV-1:0] sel;
    sel = req & (~req + 4'h1);
    return sel;
  endfunction : lowest_one

  // bus state
  logic                   addr_phase;
  logic                   dp_wr;
  logic                   next_dp_wr;
  logic [7:0]             dp_addr;
  logic [7:0]             next_dp_addr;
  logic [31:0]            next_rdata;
  logic                   wr_start;
  logic                   wr_oesel;

  // register and link state
  logic [SARH_CONV-1:0]   oe_sel;
  logic [SARH_CONV-1:0]   next_oe_sel;
  logic [SARH_DIV_W-1:0]  div_cnt;
  logic [SARH_DIV_W-1:0]  next_div_cnt;
  logic                   rise_next;
  logic [SARH_FLAG_W-1:0] flag_q;
  logic [SARH_FLAG_W-1:0] next_flag_q;
  logic [SARH_BITS-1:0]   bus_q;
  logic [SARH_BITS-1:0]   next_bus_q;

  // trigger sequencers, one per converter
  sarh_trg_e              trg_st      [SARH_CONV];
  sarh_trg_e              next_trg_st [SARH_CONV];
  logic [4:0]             lead_cnt      [SARH_CONV];
  logic [4:0]             next_lead_cnt [SARH_CONV];
  logic [SARH_CONV-1:0]   trig_n;
  logic [SARH_CONV-1:0]   next_trig_n;
  logic [SARH_CONV-1:0]   trg_busy;

  // address phase accepted when selected, nonseq and ready
  assign addr_phase = hsel_in & (htrans_in == SARH_HTRANS_NONSEQ)
                      & hready_in;
  assign wr_start   = dp_wr & (dp_addr == SARH_REG_START);
  assign wr_oesel   = dp_wr & (dp_addr == SARH_REG_OESEL);

  // busy view of the sequencers for the start register read
  always_comb begin
    for (int i = 0; i < SARH_CONV; i++) begin
      trg_busy[i] = (trg_st[i] != SARH_TRG_IDLE);
    end
  end

  // read data mux, latched during the address phase
  always_comb begin
    next_dp_wr   = addr_phase & hwrite_in;
    next_dp_addr = haddr_in[7:0];
    next_rdata   = 32'h0000_0000;
    if (addr_phase && !hwrite_in) begin
      case (haddr_in[7:0])
        SARH_REG_START:  next_rdata = {28'h0, trg_busy};
        SARH_REG_OESEL:  next_rdata = {28'h0, oe_sel};
        SARH_REG_STATUS: next_rdata = {26'h0, flag_q};
        SARH_REG_DATA:   next_rdata = {24'h0, bus_q};
        default:         next_rdata = 32'h0000_0000;
      endcase
    end
  end

  // output enable select, one converter at most
  always_comb begin
    next_oe_sel = oe_sel;
    if (wr_oesel) begin
      next_oe_sel = lowest_one(hwdata_in[SARH_CONV-1:0]);
    end
  end

  // converter clock from a 2-bit counter
  always_comb begin
    next_div_cnt = div_cnt + 2'h1;
    rise_next    = (div_cnt == SARH_DIV_PRE_RISE);
  end

  // synchronous sampling of the flag pins and result bus
  always_comb begin
    next_flag_q = link.flag_port;
    next_bus_q  = link.result_bus;
  end

  // trigger sequencers: hold low, then release on a rise
  always_comb begin
    for (int i = 0; i < SARH_CONV; i++) begin
      next_trg_st[i]   = trg_st[i];
      next_lead_cnt[i] = lead_cnt[i];
      next_trig_n[i]   = trig_n[i];
      case (trg_st[i])
        SARH_TRG_IDLE: begin
          if (wr_start && hwdata_in[i]) begin
            next_trg_st[i]   = SARH_TRG_HOLD;
            next_lead_cnt[i] = SARH_LEAD_CYC;
            next_trig_n[i]   = 1'b0;
          end
        end
        SARH_TRG_HOLD: begin
          if (lead_cnt[i] <= 5'h1) begin
            next_trg_st[i] = SARH_TRG_REL;
          end else begin
            next_lead_cnt[i] = lead_cnt[i] - 5'h1;
          end
        end
        SARH_TRG_REL: begin
          // release on the rising edge, away from falls
          if (rise_next) begin
            next_trg_st[i] = SARH_TRG_IDLE;
            next_trig_n[i] = 1'b1;
          end
        end
        default: begin
          next_trg_st[i] = SARH_TRG_IDLE;
          next_trig_n[i] = 1'b1;
        end
      endcase
    end
  end

  // bus registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      dp_wr         <= 1'b0;
      dp_addr       <= 8'h00;
      hrdata_out    <= 32'h0000_0000;
      hreadyout_out <= 1'b1;
      hresp_out     <= SARH_HRESP_OKAY;
    end else begin
      dp_wr         <= next_dp_wr;
      dp_addr       <= next_dp_addr;
      hrdata_out    <= next_rdata;
      hreadyout_out <= 1'b1;
      hresp_out     <= SARH_HRESP_OKAY;
    end
  end

  // control, divider and sample registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      oe_sel  <= SARH_OESEL_RST;
      div_cnt <= 2'h0;
      flag_q  <= 6'h00;
      bus_q   <= 8'h00;
    end else begin
      oe_sel  <= next_oe_sel;
      div_cnt <= next_div_cnt;
      flag_q  <= next_flag_q;
      bus_q   <= next_bus_q;
    end
  end

  // trigger sequencer registers
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      trig_n <= SARH_TRIG_RST;
      for (int i = 0; i < SARH_CONV; i++) begin
        trg_st[i]   <= SARH_TRG_IDLE;
        lead_cnt[i] <= 5'h00;
      end
    end else begin
      trig_n <= next_trig_n;
      for (int i = 0; i < SARH_CONV; i++) begin
        trg_st[i]   <= next_trg_st[i];
        lead_cnt[i] <= next_lead_cnt[i];
      end
    end
  end

  // control port: triggers low half, enables high half
  assign link.ctrl_port = {oe_sel, trig_n};
  assign link.conv_clk  = div_cnt[1];
endmodule : sarh_host

// ### verilog/sarh_if.sv
// link between the host port and the converters
`timescale 1ns/1ns
interface sarh_if;
  import sarh_pkg::*;

  logic                                   conv_clk;
  logic [2*SARH_CONV-1:0]                 ctrl_port;
  logic [SARH_FLAG_W-1:0]                 flag_port;
  logic [SARH_CONV-1:0][SARH_BITS-1:0]    res_data;
  logic [SARH_CONV-1:0]                   res_oe;
  logic [SARH_BITS-1:0]                   result_bus;

  // shared result bus: only an enabled converter adds its code
  always_comb begin
    result_bus = 8'h00;
    for (int i = 0; i < SARH_CONV; i++) begin
      if (res_oe[i]) begin
        result_bus = result_bus | res_data[i];
      end
    end
  end

  modport host   (output conv_clk, ctrl_port,
                  input  flag_port, result_bus);
  modport device (input  conv_clk, ctrl_port,
                  output flag_port, res_data, res_oe);
endinterface : sarh_if

// ### verilog/sarh_pkg.sv
// shared constants for the converter sequencer and its host port
package sarh_pkg;

  // converter geometry
  localparam int          SARH_BITS   = 8;
  localparam int          SARH_CONV   = 4;
  localparam int          SARH_FLAG_W = 6;
  localparam int          SARH_DIV_W  = 2;
  localparam logic [7:0]  SARH_PRESET = 8'h80;
  localparam logic [3:0]  SARH_STEP_W0 = 4'h0;
  localparam logic [3:0]  SARH_LAST_DECISION = 4'h8;
  localparam logic [3:0]  SARH_DONE_STEP = 4'h9;

  // timing, figures in ns and derived core clock cycles
  localparam int          SARH_CLK_NS     = 100;
  localparam int          SARH_T_LEAD_NS  = 1500;
  localparam int          SARH_T_GUARD_NS = 200;
  localparam int          SARH_T_CONV_NS  = 15000;
  localparam logic [4:0]  SARH_LEAD_CYC   =
    5'((SARH_T_LEAD_NS + SARH_CLK_NS - 1) / SARH_CLK_NS);
  localparam logic [1:0]  SARH_DIV_PRE_RISE = 2'h1;

  // register offsets (byte addresses)
  localparam logic [7:0]  SARH_REG_START  = 8'h00;
  localparam logic [7:0]  SARH_REG_OESEL  = 8'h04;
  localparam logic [7:0]  SARH_REG_STATUS = 8'h08;
  localparam logic [7:0]  SARH_REG_DATA   = 8'h0C;

  // reset values and bus constants
  localparam logic [3:0]  SARH_OESEL_RST  = 4'h0;
  localparam logic [3:0]  SARH_TRIG_RST   = 4'hF;
  localparam logic [1:0]  SARH_HTRANS_NONSEQ = 2'h2;
  localparam logic        SARH_HRESP_OKAY = 1'b0;

  // trigger sequencer states
  typedef enum logic [2:0] {
    SARH_TRG_IDLE = 3'b001,
    SARH_TRG_HOLD = 3'b010,
    SARH_TRG_REL  = 3'b100
  } sarh_trg_e;

endpackage : sarh_pkg

// ### verilog/sarh_sar_chan.sv
// one successive approximation channel with output latch
`timescale 1ns/1ns
module sarh_sar_chan (
  // clock and reset
  input  wire logic                       core_clk_in,
  input  wire logic                       rst_in,
  // converter controls
  input  wire logic                       conv_fall_in,
  input  wire logic                       trigger_n_in,
  input  wire logic                       comp_in,
  input  wire logic                       oe_in,
  // results
  output logic [sarh_pkg::SARH_BITS-1:0]  result_out,
  output logic                            result_oe_out,
  output logic                            done_out
);
  import sarh_pkg::*;

  logic [SARH_BITS-1:0] mask;
  logic [SARH_BITS-1:0] next_mask;
  logic [SARH_BITS-1:0] next_result;
  logic [3:0]           step;
  logic [3:0]           next_step;
  logic                 next_done;
  logic                 next_oe;

  // bit decisions on falling converter clock edges
  always_comb begin
    next_result = result_out;
    next_mask   = mask;
    next_step   = step;
    next_done   = done_out;
    next_oe     = oe_in;
    if (!trigger_n_in) begin
      next_result = SARH_PRESET;
      next_mask   = SARH_PRESET;
      next_step   = SARH_STEP_W0;
      next_done   = 1'b0;
    end else if (conv_fall_in && !done_out) begin
      next_step = step + 4'h1;
      if (step < SARH_LAST_DECISION) begin
        // comparator high keeps the trial bit
        if (!comp_in) begin
          next_result = result_out & ~mask;
        end
        next_result = next_result | (mask >> 1);
        next_mask   = mask >> 1;
      end else begin
        next_done = 1'b1;
      end
    end
  end

  // result latch holds until the next trigger
  always_ff @(posedge core_clk_in) begin
    if (rst_in) begin
      result_out    <= 8'h00;
      mask          <= 8'h00;
      step          <= SARH_DONE_STEP;
      done_out      <= 1'b1;
      result_oe_out <= 1'b0;
    end else begin
      result_out    <= next_result;
      mask          <= next_mask;
      step          <= next_step;
      done_out      <= next_done;
      result_oe_out <= next_oe;
    end
  end
endmodule : sarh_sar_chan
